// >>> pkg/return_exec_regs.vh
// constants for the return-instruction execution block
// assumes inclusion by bare name from design files
`ifndef RETURN_EXEC_REGS_VH
`define RETURN_EXEC_REGS_VH

// ==========================================
// opcode patterns
`define RFI_OPCODE_MASK   16'hfffe
`define RFI_OPCODE_VALUE  16'h0010
`define RWL_OPCODE_MASK   16'hff00
`define RWL_OPCODE_VALUE  16'h0c00
`define RFI_SHADOW_BIT    0

// ==========================================
// q-phase numbering and reset values
`define Q_PHASE_Q1        2'h0
`define Q_PHASE_Q4        2'h3
`define PC_WIDTH          21
`define ACC_RESET         8'h00
`define FLAGS_RESET       8'h00
`define BANK_RESET        8'h00

`endif

// >>> hdl/return_decode.v
// opcode classifier for the two return instructions
// assumes the instruction word is stable through the whole instruction cycle
`include "return_exec_regs.vh"
`default_nettype none

module return_decode
(
    // instruction word
    input  wire [15:0] instr,
    // classification
    output wire        is_return_from_irq,
    output wire        is_return_with_literal,
    output wire        shadow_select,
    output wire [7:0]  literal
);

    // ==========================================
    // pattern match
    assign is_return_from_irq     = (instr & `RFI_OPCODE_MASK) == `RFI_OPCODE_VALUE;
    assign is_return_with_literal = (instr & `RWL_OPCODE_MASK) == `RWL_OPCODE_VALUE;
    assign shadow_select          = instr[`RFI_SHADOW_BIT];
    assign literal                = instr[7:0];

endmodule // return_decode

`default_nettype wire

// >>> hdl/return_instr_exec.v
// execution of return-from-interrupt and return-with-literal
// assumes q_phase advances once per clock, instr valid from q1 of each cycle
//
// Behaviour
// - return_from_irq pops stack and loads stack_top into program_counter
// - return_from_irq sets the high global interrupt enable bit or the low peripheral interrupt enable bit
// - with s=1, shadow acc, flags, bank copied into live registers
// - with s=0, accumulator, flags and bank select untouched
// - return_from_irq never writes the program counter latch registers
// - return_with_literal loads literal to acc, pops stack, keeps latches
`include "return_exec_regs.vh"
`default_nettype none

module return_instr_exec
(
    // clock and reset
    input  wire                   clock,
    input  wire                   arst_n,
    // instruction cycle timing
    input  wire [1:0]             q_phase,
    input  wire [15:0]            instr,
    input  wire                   instr_valid,
    // stack interface
    input  wire [`PC_WIDTH-1:0]   stack_top,
    output wire                   stack_pop,
    // interrupt controller
    input  wire                   irq_high_active,
    output wire                   set_global_irq_enable_high,
    output wire                   set_periph_irq_enable_low,
    // shadow copies
    input  wire [7:0]             acc_shadow,
    input  wire [7:0]             flags_shadow,
    input  wire [7:0]             bank_shadow,
    // live registers
    output reg  [`PC_WIDTH-1:0]   program_counter,
    output reg  [7:0]             accumulator,
    output reg  [7:0]             flags,
    output reg  [7:0]             bank_select_reg,
    output wire                   pc_latch_write,
    // flush of the second cycle
    output reg                    second_cycle_nop
);

    wire is_rfi;
    wire is_rwl;
    wire shadow_sel;
    wire [7:0] lit;

    // ==========================================
    // decode
    return_decode return_decode_inst
    (
        .instr                  (instr),
        .is_return_from_irq     (is_rfi),
        .is_return_with_literal (is_rwl),
        .shadow_select          (shadow_sel),
        .literal                (lit)
    );

    // execute only in a real first cycle; second cycle ignores its fetch
    wire exec_q4 = instr_valid & ~second_cycle_nop & (q_phase == `Q_PHASE_Q4);
    wire rfi_q4  = exec_q4 & is_rfi;
    wire rwl_q4  = exec_q4 & is_rwl;

    // ==========================================
    // handshake strobes, one clock wide in q4
    assign stack_pop                  = rfi_q4 | rwl_q4;
    assign set_global_irq_enable_high = rfi_q4 & irq_high_active;
    assign set_periph_irq_enable_low  = rfi_q4 & ~irq_high_active;
    // latches are the other path; neither return writes them
    assign pc_latch_write             = 1'b0;

    // ==========================================
    // program counter load from stack top
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            program_counter <= {`PC_WIDTH{1'b0}};
        else if (rfi_q4 | rwl_q4)
            program_counter <= stack_top;
    end

    // ==========================================
    // accumulator, flags and bank select update
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            accumulator     <= `ACC_RESET;
            flags           <= `FLAGS_RESET;
            bank_select_reg <= `BANK_RESET;
        end
        else if (rwl_q4)
        begin
            accumulator <= lit;
        end
        else if (rfi_q4 & shadow_sel)
        begin
            accumulator     <= acc_shadow;
            flags           <= flags_shadow;
            bank_select_reg <= bank_shadow;
        end
        // s=0 falls through: nothing written
    end

    // ==========================================
    // second cycle marker: set at q4, held for one full cycle
    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            second_cycle_nop <= 1'b0;
        else if (rfi_q4 | rwl_q4)
            second_cycle_nop <= 1'b1;
        else if (q_phase == `Q_PHASE_Q4)
            second_cycle_nop <= 1'b0;
    end

endmodule // return_instr_exec

`default_nettype wire

// >>> tb/return_exec_check_assertions.sv
// checker for the return execution block
// assumes it is bound to return_instr_exec
`include "return_exec_regs.vh"
`default_nettype none
module return_exec_check
(
    // watched ports
    input wire logic        clock, arst_n, instr_valid, stack_pop, irq_high_active,
    input wire logic        set_global_irq_enable_high, set_periph_irq_enable_low,
    input wire logic        pc_latch_write, second_cycle_nop,
    input wire logic [1:0]  q_phase,
    input wire logic [15:0] instr,
    input wire logic [20:0] stack_top, program_counter,
    input wire logic [7:0]  acc_shadow, flags_shadow, bank_shadow,
    input wire logic [7:0]  accumulator, flags, bank_select_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ==========================================
    // a return is taken only in q4 outside the nop cycle
    wire q4  = q_phase == 2'h3 && instr_valid && !second_cycle_nop;
    wire rfi = q4 && instr[15:1] == 15'h0008;
    wire rwl = q4 && instr[15:8] == 8'h0c;
    a_pop_strobe: assert property ((rfi || rwl) |-> stack_pop) else $error("no pop");
    a_pc_load: assert property ((rfi || rwl) |=> program_counter == $past(stack_top))
        else $error("pc not loaded");
    a_irq_enable: assert property (rfi |-> set_global_irq_enable_high == irq_high_active
        && set_periph_irq_enable_low == !irq_high_active) else $error("bad enable");
    a_shadow_copy: assert property (rfi && instr[0] |=> accumulator == $past(acc_shadow)
        && flags == $past(flags_shadow) && bank_select_reg == $past(bank_shadow))
        else $error("shadow not copied");
    a_regs_kept: assert property (rfi && !instr[0] |=> $stable(accumulator) && $stable(flags)
        && $stable(bank_select_reg)) else $error("regs changed");
    a_latch_quiet: assert property (!pc_latch_write) else $error("latch written");
    a_literal_load: assert property (rwl |=> accumulator == $past(instr[7:0]))
        else $error("literal lost");
    a_nop_cycle: assert property ((rfi || rwl) |=> second_cycle_nop [*4])
        else $error("nop cycle short");
    a_nop_no_pop: assert property (second_cycle_nop |-> !stack_pop)
        else $error("pop in nop cycle");
    // main scenarios
    c_rfi_shadow: cover property (rfi && instr[0]);
    c_rfi_plain: cover property (rfi && !instr[0]);
    c_literal: cover property (rwl);
endmodule // return_exec_check
`default_nettype wire

// >>> tb/return_instr_exec_test.sv
// self-checking bench for the return execution block
// assumes the bench drives q_phase and all inputs at the falling edge
`include "return_exec_regs.vh"
`default_nettype none
module return_instr_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, arst_n = 0, instr_valid = 0, irq_high_active = 0;
    logic [1:0] q_phase = 2'h0;
    logic [15:0] instr = 16'h0000;
    logic [20:0] stack_top = 21'h0abcd, program_counter;
    logic [7:0] acc_shadow = 8'ha1, flags_shadow = 8'hb2, bank_shadow = 8'hc3;
    logic [7:0] accumulator, flags, bank_select_reg;
    logic stack_pop, set_global_irq_enable_high, set_periph_irq_enable_low;
    logic pc_latch_write, second_cycle_nop, p, h, l, n, q;
    int errors = 0, num_checks = 0;
    return_instr_exec return_instr_exec_inst (.*);
    initial forever #5 clock = ~clock;
    task chk(input logic ok);
        num_checks++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    // one instruction over two cycles, strobes caught in q4
    task exec(input logic [15:0] i);
        instr = i;
        instr_valid = 1;
        for (int k = 0; k < 8; k++)
        begin
            @(negedge clock) q_phase = k[1:0];
            #1 if (k == 3) {p, h, l} = {stack_pop, set_global_irq_enable_high,
                set_periph_irq_enable_low};
            if (k == 5) n = second_cycle_nop;
            if (k == 7) q = stack_pop;
        end
        instr_valid = 0;
    endtask
    task t_rfi_shadow;
        irq_high_active = 1;
        exec(16'h0011);
        chk(p && h && !l && n && !q);
        chk(program_counter === 21'h0abcd);
        chk({accumulator, flags, bank_select_reg} === 24'ha1b2c3);
    endtask
    task t_rfi_plain;
        {irq_high_active, acc_shadow, stack_top} = {1'b0, 8'h11, 21'h1f00e};
        exec(16'h0010);
        chk(p && !h && l);
        chk({accumulator, program_counter} === {8'ha1, 21'h1f00e});
    endtask
    task t_literal;
        stack_top = 21'h12345;
        exec(16'h0cff);
        chk({accumulator, pc_latch_write} === 9'h1fe);
        chk(program_counter === 21'h12345 && p && !q);
        chk({flags, bank_select_reg} === 16'hb2c3);
    endtask
    task results;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(negedge clock);
        arst_n = 1;
        t_rfi_shadow;
        t_rfi_plain;
        t_literal;
        results;
    end
    initial
    begin
        #5000 errors++;
        results;
    end
endmodule // return_instr_exec_test
bind return_instr_exec return_exec_check return_exec_check_inst (.*);
`default_nettype wire
